// ==== shared/trap_pkg.sv ====
// Constants and types for the non-maskable exception block
package trap_pkg;
  localparam int unsigned CCR_W = 8;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned NUM_MASKABLE = 20;
  localparam int unsigned SEL_W = 5;
  localparam int unsigned VEC_W = 5;
  localparam int unsigned XBIT_POS = 6;
  localparam int unsigned IBIT_POS = 4;
  localparam int unsigned STACK_BYTES = 9;
  localparam int unsigned STK_CNT_W = 4;
  localparam logic [7:0] TEST_OPCODE = 8'h00;
  // Source indices used to pick a vector; maskable sources follow at MASKABLE_BASE
  localparam logic [VEC_W-1:0] VEC_NONE = 5'h00;
  localparam logic [VEC_W-1:0] VEC_CLKMON = 5'h01;
  localparam logic [VEC_W-1:0] VEC_WATCHDOG = 5'h02;
  localparam logic [VEC_W-1:0] VEC_ILLEGAL = 5'h03;
  localparam logic [VEC_W-1:0] VEC_SWTRAP = 5'h04;
  localparam logic [VEC_W-1:0] VEC_NMI = 5'h05;
  localparam logic [VEC_W-1:0] VEC_MASKABLE_BASE = 5'h06;
  // Stacked byte selectors, in push order
  typedef enum logic [STK_CNT_W-1:0] {
    STK_PCL, STK_PCH, STK_IYL, STK_IYH, STK_IXL, STK_IXH, STK_ACCA, STK_ACCB, STK_CCR
  } stack_sel_type;
endpackage : trap_pkg

// ==== rtl/maskable_arbiter.sv ====
// Fixed priority arbiter for maskable sources with one promotable source
`timescale 1ns/100ps
module maskable_arbiter
  import trap_pkg::*;
(
  input wire logic [NUM_MASKABLE-1:0] req,
  input wire logic [NUM_MASKABLE-1:0] local_en,
  input wire logic ibit,
  input wire logic [SEL_W-1:0] promote_sel,
  output logic any,
  output logic [VEC_W-1:0] vec
);
  logic [NUM_MASKABLE-1:0] gated;
  // ----------------------------------------
  // Gating
  // ----------------------------------------
  // Source 0 is the external pin and has no local enable
  always_comb begin
    gated = req & ~{NUM_MASKABLE{ibit}};
    gated = gated & {local_en[NUM_MASKABLE-1:1], 1'b1};
  end
  // ----------------------------------------
  // Priority
  // ----------------------------------------
  always_comb begin
    any = |gated;
    vec = VEC_NONE;
    for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
      if (gated[i]) begin
        vec = VEC_MASKABLE_BASE + VEC_W'(i);
      end
    end
    if (promote_sel < SEL_W'(NUM_MASKABLE) && gated[promote_sel]) begin
      vec = VEC_MASKABLE_BASE + promote_sel;
    end
  end
endmodule : maskable_arbiter

// ==== rtl/illegal_decoder.sv ====
// Illegal opcode detection over the four opcode map pages
`timescale 1ns/100ps
module illegal_decoder
  import trap_pkg::*;
(
  input wire logic [1:0] page,
  input wire logic [7:0] opcode,
  input wire logic [255:0] legal_p0,
  input wire logic [255:0] legal_p1,
  input wire logic [255:0] legal_p2,
  input wire logic [255:0] legal_p3,
  input wire logic special_mode,
  output logic illegal
);
  // Legal maps come in as inputs so the table lives with the instruction decoder
  function automatic logic is_legal(input logic [255:0] map, input logic [7:0] op);
    is_legal = map[op];
  endfunction : is_legal
  always_comb begin
    case (page)
      2'd0: illegal = !is_legal(legal_p0, opcode);
      2'd1: illegal = !is_legal(legal_p1, opcode);
      2'd2: illegal = !is_legal(legal_p2, opcode);
      default: illegal = !is_legal(legal_p3, opcode);
    endcase
    if (page == 2'd0 && opcode == TEST_OPCODE) begin
      illegal = !special_mode;
    end
  end
endmodule : illegal_decoder

// ==== rtl/nonmaskable_trap_logic.sv ====
// Non-maskable exception control: mask flip-flop, stop wake-up, traps, stacking
// Notes on behaviour
// - every reset sets the non-maskable mask bit.
// - mask bit is set-reset; set by reset or non-maskable acknowledge.
// - cleared only by a flags write with bit 6 zero; one leaves it.
// - only flags transfer and return-from-interrupt clear it; neither of them sets it.
// - flags stacked with mask clear, then mask set on entry.
// - stop halts clocks; reset, maskable pin or non-maskable pin wakes.
// - mask clear at wake by non-maskable pin gives normal service.
// - mask set still wakes; execution continues, no service.
// - unimplemented opcodes on all pages trap to illegal vector.
// - illegal trap stacks the address of the offending opcode.
// - test opcode illegal in normal modes, legal in special modes.
// - software trap ignores both masks, stacks and sets maskable mask.
// - software trap beats pending interrupts only when both masks set.
// - software trap opcode not fetched while another interrupt pends.
// - after software trap starts, nothing else until its vector fetch.
// - twenty maskable sources gated by mask bit and local enables.
// - fixed maskable priority with one promotable source.
// - most sources have their own vector.
// - unmasked order: reset, clock monitor, watchdog, illegal, pin.
// - push order PCL PCH IYL IYH IXL IXH A B flags.
`timescale 1ns/100ps
module nonmaskable_trap_logic
  import trap_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic nonmaskable_irq_pin_n,
  input wire logic maskable_irq_pin_n,
  input wire logic [NUM_MASKABLE-1:1] periph_req,
  input wire logic [NUM_MASKABLE-1:1] periph_en,
  input wire logic [trap_pkg::SEL_W-1:0] promote_sel,
  input wire logic clock_monitor_fail,
  input wire logic watchdog_fail,
  input wire logic special_mode,
  input wire logic instr_boundary,
  input wire logic [1:0] opcode_page,
  input wire logic [7:0] opcode,
  input wire logic opcode_valid,
  input wire logic [255:0] legal_p0,
  input wire logic [255:0] legal_p1,
  input wire logic [255:0] legal_p2,
  input wire logic [255:0] legal_p3,
  input wire logic swtrap_decoded,
  input wire logic stop_decoded,
  input wire logic ccr_write,
  input wire logic [trap_pkg::CCR_W-1:0] ccr_wdata,
  input wire logic [trap_pkg::ADDR_W-1:0] opcode_addr,
  input wire logic [trap_pkg::ADDR_W-1:0] next_pc,
  input wire logic [trap_pkg::ADDR_W-1:0] iy,
  input wire logic [trap_pkg::ADDR_W-1:0] ix,
  input wire logic [7:0] acc_a,
  input wire logic [7:0] acc_b,
  input wire logic [trap_pkg::CCR_W-1:0] ccr_in,
  input wire logic stack_ready,
  input wire logic vector_fetched,
  output logic xmask,
  output logic imask,
  output logic clocks_run,
  output logic resume_after_stop,
  output logic swtrap_fetch_ok,
  output logic stack_push,
  output logic [7:0] stack_data,
  output logic vector_req,
  output logic [trap_pkg::VEC_W-1:0] vector_sel
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {ST_RUN, ST_STOP, ST_STACK, ST_VECTOR} phase_type;
  typedef struct packed {
    phase_type phase;
    logic xmask;
    logic imask;
    logic [STK_CNT_W-1:0] idx;
    logic [VEC_W-1:0] vec;
    logic [ADDR_W-1:0] ret_pc;
    logic [ADDR_W-1:0] iy;
    logic [ADDR_W-1:0] ix;
    logic [7:0] a;
    logic [7:0] b;
    logic [CCR_W-1:0] condition_code_reg;
    logic is_nmi;
    logic resume;
    logic push;
    logic [7:0] data;
  } state_type;
  state_type state_reg;
  state_type state_next;
  logic m_any;
  logic [VEC_W-1:0] m_vec;
  logic illegal;
  logic nmi_req;
  logic swtrap_now;
  logic [VEC_W-1:0] nm_vec;
  logic nm_any;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  maskable_arbiter maskable_arbiter_i (
    .req({periph_req, !maskable_irq_pin_n}),
    .local_en({periph_en, 1'b1}),
    .ibit(state_reg.imask),
    .promote_sel(promote_sel),
    .any(m_any),
    .vec(m_vec)
  );
  illegal_decoder illegal_decoder_i (
    .page(opcode_page),
    .opcode(opcode),
    .legal_p0(legal_p0),
    .legal_p1(legal_p1),
    .legal_p2(legal_p2),
    .legal_p3(legal_p3),
    .special_mode(special_mode),
    .illegal(illegal)
  );
  // ----------------------------------------
  // Non-maskable resolution
  // ----------------------------------------
  always_comb begin
    nmi_req = !nonmaskable_irq_pin_n && !state_reg.xmask;
    nm_any = 1'b1;
    if (clock_monitor_fail) begin
      nm_vec = VEC_CLKMON;
    end else if (watchdog_fail) begin
      nm_vec = VEC_WATCHDOG;
    end else if (opcode_valid && illegal) begin
      nm_vec = VEC_ILLEGAL;
    end else if (nmi_req) begin
      nm_vec = VEC_NMI;
    end else begin
      nm_vec = VEC_NONE;
      nm_any = 1'b0;
    end
    // Fetch of the trap opcode is blocked while anything else pends
    swtrap_fetch_ok = !nm_any && !m_any;
    swtrap_now = opcode_valid && swtrap_decoded && swtrap_fetch_ok;
  end
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.push = 1'b0;
    state_next.resume = 1'b0;
    // Mask bit clear path only; writing a one never sets it
    if (ccr_write && !ccr_wdata[XBIT_POS]) begin
      state_next.xmask = 1'b0;
    end
    if (ccr_write) begin
      state_next.imask = ccr_wdata[IBIT_POS];
    end
    case (state_reg.phase)
      ST_RUN: begin
        if (instr_boundary && (nm_any || m_any || swtrap_now)) begin
          state_next.phase = ST_STACK;
          state_next.idx = STK_PCL;
          state_next.vec = nm_any ? nm_vec : (swtrap_now ? VEC_SWTRAP : m_vec);
          state_next.is_nmi = nm_any && nm_vec == VEC_NMI;
          // Illegal trap returns to the offending opcode itself
          state_next.ret_pc = next_pc;
          if (nm_any && nm_vec == VEC_ILLEGAL) begin
            state_next.ret_pc = opcode_addr;
          end
          state_next.iy = iy;
          state_next.ix = ix;
          state_next.a = acc_a;
          state_next.b = acc_b;
          state_next.condition_code_reg = ccr_in;
          state_next.condition_code_reg[XBIT_POS] = state_reg.xmask;
        end else if (instr_boundary && opcode_valid && stop_decoded) begin
          state_next.phase = ST_STOP;
        end
      end
      ST_STOP: begin
        if (!nonmaskable_irq_pin_n) begin
          if (!state_reg.xmask) begin
            state_next.phase = ST_STACK;
            state_next.idx = STK_PCL;
            state_next.vec = VEC_NMI;
            state_next.is_nmi = 1'b1;
            state_next.ret_pc = next_pc;
            state_next.iy = iy;
            state_next.ix = ix;
            state_next.a = acc_a;
            state_next.b = acc_b;
            state_next.condition_code_reg = ccr_in;
            state_next.condition_code_reg[XBIT_POS] = 1'b0;
          end else begin
            state_next.phase = ST_RUN;
            state_next.resume = 1'b1;
          end
        end else if (!maskable_irq_pin_n) begin
          // Pin wakes; service follows if unmasked at the next boundary
          state_next.phase = ST_RUN;
          state_next.resume = state_reg.imask;
        end
      end
      ST_STACK: begin
        if (stack_ready) begin
          state_next.push = 1'b1;
          case (state_reg.idx)
            STK_PCL: state_next.data = state_reg.ret_pc[7:0];
            STK_PCH: state_next.data = state_reg.ret_pc[15:8];
            STK_IYL: state_next.data = state_reg.iy[7:0];
            STK_IYH: state_next.data = state_reg.iy[15:8];
            STK_IXL: state_next.data = state_reg.ix[7:0];
            STK_IXH: state_next.data = state_reg.ix[15:8];
            STK_ACCA: state_next.data = state_reg.a;
            STK_ACCB: state_next.data = state_reg.b;
            default: state_next.data = state_reg.condition_code_reg;
          endcase
          if (state_reg.idx == STK_CCR) begin
            state_next.phase = ST_VECTOR;
            state_next.imask = 1'b1;
            if (state_reg.is_nmi) begin
              state_next.xmask = 1'b1;
            end
          end else begin
            state_next.idx = state_reg.idx + STK_CNT_W'(1);
          end
        end
      end
      ST_VECTOR: begin
        // Vector held until fetched, so a trap cannot be overtaken
        if (vector_fetched) begin
          state_next.phase = ST_RUN;
        end
      end
      default: state_next.phase = ST_RUN;
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
      state_reg.phase <= ST_RUN;
      state_reg.xmask <= 1'b1;
      state_reg.imask <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign xmask = state_reg.xmask;
  assign imask = state_reg.imask;
  assign clocks_run = state_reg.phase != ST_STOP;
  assign resume_after_stop = state_reg.resume;
  assign stack_push = state_reg.push;
  assign stack_data = state_reg.data;
  assign vector_req = state_reg.phase == ST_VECTOR;
  assign vector_sel = state_reg.vec;
endmodule : nonmaskable_trap_logic

// ==== testbench/nonmaskable_trap_logic_properties.sv ====
// Concurrent checks on the exception block ports
`timescale 1ns/100ps
module nonmaskable_trap_logic_properties
  import trap_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic nonmaskable_irq_pin_n,
  input wire logic ccr_write,
  input wire logic [trap_pkg::CCR_W-1:0] ccr_wdata,
  input wire logic vector_fetched,
  input wire logic xmask,
  input wire logic imask,
  input wire logic clocks_run,
  input wire logic swtrap_fetch_ok,
  input wire logic stack_push,
  input wire logic vector_req
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  mask_on_reset_a: assert property ($rose(nrst) |-> xmask && imask)
    else $error("mask bits clear after reset");
  xmask_clear_a: assert property (ccr_write && !ccr_wdata[6] && !stack_push |=> !xmask)
    else $error("flags write with bit 6 low kept mask");
  xmask_keep_a: assert property (ccr_write && ccr_wdata[6] && !stack_push |=> $stable(xmask))
    else $error("flags write with bit 6 high changed mask");
  xmask_set_a: assert property ($rose(xmask) |-> stack_push || $past(stack_push))
    else $error("mask set outside entry");
  pin_wake_a: assert property (!clocks_run && !nonmaskable_irq_pin_n |-> ##[1:2] clocks_run)
    else $error("pin did not wake from stop");
  vector_hold_a: assert property (vector_req && !vector_fetched |=> vector_req)
    else $error("vector request dropped early");
  trap_block_a: assert property (!$past(nonmaskable_irq_pin_n) && !nonmaskable_irq_pin_n
    && !xmask |-> !swtrap_fetch_ok)
    else $error("trap fetch allowed while pending");
  entry_mask_a: assert property ($rose(vector_req) |-> imask)
    else $error("mask not set at entry");
  flags_last_a: assert property ($rose(vector_req) |-> stack_push)
    else $error("vector before last push");
endmodule : nonmaskable_trap_logic_properties

bind nonmaskable_trap_logic nonmaskable_trap_logic_properties nonmaskable_trap_logic_properties_i (
  .clk(clk), .nrst(nrst), .nonmaskable_irq_pin_n(nonmaskable_irq_pin_n),
  .ccr_write(ccr_write), .ccr_wdata(ccr_wdata), .vector_fetched(vector_fetched),
  .xmask(xmask), .imask(imask), .clocks_run(clocks_run), .swtrap_fetch_ok(swtrap_fetch_ok),
  .stack_push(stack_push), .vector_req(vector_req)
);

// ==== testbench/irq_source_model.sv ====
// Level interrupt sources on the two request pins
`timescale 1ns/100ps
module irq_source_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic nmi_on,
  input wire logic irq_on,
  output logic nonmaskable_irq_pin_n,
  output logic maskable_irq_pin_n
);
  // ----
  // One registered driver per pin, driven high when idle
  // ----
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nonmaskable_irq_pin_n <= 1'b1;
      maskable_irq_pin_n <= 1'b1;
    end else begin
      nonmaskable_irq_pin_n <= !nmi_on;
      maskable_irq_pin_n <= !irq_on;
    end
  end
endmodule : irq_source_model

// ==== testbench/nonmaskable_trap_logic_tb.sv ====
// Self-checking bench for the exception block
`timescale 1ns/100ps
module nonmaskable_trap_logic_tb;
  import trap_pkg::*;
  logic clk, nrst, nmi_on, irq_on, nonmaskable_irq_pin_n, maskable_irq_pin_n;
  logic special_mode, instr_boundary, opcode_valid, swtrap_decoded, stop_decoded;
  logic ccr_write, vector_fetched, clock_monitor_fail, watchdog_fail;
  logic stack_ready = 1'b0;
  logic xmask, imask, clocks_run, resume_after_stop, swtrap_fetch_ok, stack_push, vector_req;
  logic [19:1] periph_req, periph_en;
  logic [4:0] promote_sel, vector_sel;
  logic [1:0] opcode_page;
  logic [7:0] opcode, ccr_wdata, acc_a, acc_b, ccr_in, stack_data;
  logic [15:0] opcode_addr, next_pc, iy, ix;
  logic [255:0] legal_p0, legal_p1, legal_p2, legal_p3;
  int n_mismatch = 0;
  int samples_checked = 0;
  // ----
  // Clock, partner, design
  // ----
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  // Stack ready only every other cycle to exercise the wait
  always @(posedge clk) stack_ready <= !stack_ready;
  irq_source_model irq_source_model_i (.clk, .nrst, .nmi_on, .irq_on, .nonmaskable_irq_pin_n,
    .maskable_irq_pin_n);
  nonmaskable_trap_logic nonmaskable_trap_logic_i (.clk, .nrst, .nonmaskable_irq_pin_n,
    .maskable_irq_pin_n, .periph_req, .periph_en, .promote_sel, .clock_monitor_fail,
    .watchdog_fail, .special_mode, .instr_boundary, .opcode_page, .opcode, .opcode_valid,
    .legal_p0, .legal_p1, .legal_p2, .legal_p3, .swtrap_decoded, .stop_decoded, .ccr_write,
    .ccr_wdata, .opcode_addr, .next_pc, .iy, .ix, .acc_a, .acc_b, .ccr_in, .stack_ready,
    .vector_fetched, .xmask, .imask, .clocks_run, .resume_after_stop, .swtrap_fetch_ok,
    .stack_push, .stack_data, .vector_req, .vector_sel);
  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic flags_write(input logic [7:0] d);
    @(posedge clk) ccr_write <= 1'b1;
    ccr_wdata <= d;
    @(posedge clk) ccr_write <= 1'b0;
    @(posedge clk) #1;
  endtask : flags_write
  // Boundary, nine pushes, vector fetch
  task automatic run_entry(input logic [15:0] pc, input logic [4:0] vec, input logic [7:0] f);
    logic [7:0] e [9];
    int n;
    e = '{pc[7:0], pc[15:8], 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC, f};
    n = 0;
    @(posedge clk) instr_boundary <= 1'b1;
    @(posedge clk) instr_boundary <= 1'b0;
    for (int c = 0; c < 40 && !(vector_req === 1'b1); c++) begin
      @(posedge clk) #1;
      if (stack_push === 1'b1 && n < 9) begin
        check(stack_data, e[n]);
        n++;
      end
    end
    check(n, 9);
    check(vector_sel, vec);
    @(posedge clk) vector_fetched <= 1'b1;
    @(posedge clk) vector_fetched <= 1'b0;
    check(imask, 1'b1);
  endtask : run_entry
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // ----
  // Scenarios
  // ----
  task automatic t_flags;
    check(xmask, 1'b1);
    check(clocks_run, 1'b1);
    flags_write(8'h50);
    check(xmask, 1'b1);
    flags_write(8'h00);
    check(xmask, 1'b0);
    $display("flags test done");
  endtask : t_flags
  task automatic t_entries;
    irq_on <= 1'b1;
    run_entry(next_pc, VEC_MASKABLE_BASE, 8'h80);
    irq_on <= 1'b0;
    nmi_on <= 1'b1;
    run_entry(next_pc, VEC_NMI, 8'h80);
    nmi_on <= 1'b0;
    check(xmask, 1'b1);
    opcode <= TEST_OPCODE;
    run_entry(opcode_addr, VEC_ILLEGAL, 8'hC0);
    @(posedge clk) special_mode <= 1'b1;
    @(posedge clk) #1;
    check(swtrap_fetch_ok, 1'b1);
    @(posedge clk) special_mode <= 1'b0;
    opcode <= 8'h01;
    swtrap_decoded <= 1'b1;
    run_entry(next_pc, VEC_SWTRAP, 8'hC0);
    swtrap_decoded <= 1'b0;
    $display("entry test done");
  endtask : t_entries
  task automatic t_stop;
    logic seen;
    seen = 1'b0;
    @(posedge clk) stop_decoded <= 1'b1;
    instr_boundary <= 1'b1;
    @(posedge clk) stop_decoded <= 1'b0;
    instr_boundary <= 1'b0;
    @(posedge clk) #1;
    check(clocks_run, 1'b0);
    nmi_on <= 1'b1;
    repeat (6) begin
      @(posedge clk) #1;
      seen = seen | (resume_after_stop === 1'b1);
    end
    check(clocks_run, 1'b1);
    check(seen, 1'b1);
    check(vector_req, 1'b0);
    nmi_on <= 1'b0;
    $display("stop test done");
  endtask : t_stop
  initial begin
    #(25 * 4000);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {nrst, nmi_on, irq_on, special_mode, instr_boundary, swtrap_decoded, stop_decoded} = '0;
    {ccr_write, ccr_wdata, vector_fetched, clock_monitor_fail, watchdog_fail} = '0;
    {periph_req, periph_en, promote_sel, opcode_page} = '0;
    opcode_valid = 1'b1;
    opcode = 8'h01;
    legal_p0 = ~256'h1;
    legal_p1 = '1;
    legal_p2 = '1;
    legal_p3 = '1;
    {opcode_addr, next_pc, iy, ix} = {16'h1FFE, 16'h2000, 16'h3412, 16'h7856};
    {acc_a, acc_b, ccr_in} = {8'h9A, 8'hBC, 8'hC0};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk) #1;
    t_flags();
    t_entries();
    t_stop();
    tally_and_finish();
  end
endmodule : nonmaskable_trap_logic_tb
